/* auto_mute_pkg.sv */
package auto_mute_pkg;

  localparam int REG_DATA_W = 8;
  localparam int WB_DATA_W = 32;
  localparam int WB_ADR_W = 10;
  localparam int IDX_W = 8;
  localparam int SAMPLE_W = 32;
  localparam int RUN_W = 19;
  localparam int CHANNELS = 2;
  localparam int CH_LEFT = 0;
  localparam int CH_RIGHT = 1;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_AUTO_MUTE_TIME = 8'h3B;
  localparam logic [IDX_W-1:0] IDX_VOLUME_LINK_CONTROL = 8'h3C;
  localparam logic [IDX_W-1:0] IDX_LEFT_VOLUME = 8'h3D;
  localparam logic [IDX_W-1:0] IDX_RIGHT_VOLUME = 8'h3E;
  localparam logic [IDX_W-1:0] IDX_MUTE_STATUS = 8'h40;

  // field positions
  localparam int LEFT_TIME_LSB = 4;
  localparam int RIGHT_TIME_LSB = 0;
  localparam int TIME_FIELD_W = 3;
  localparam int LINK_LSB = 0;
  localparam int LINK_FIELD_W = 2;
  localparam int STAT_LEFT_AUTO = 0;
  localparam int STAT_RIGHT_AUTO = 1;
  localparam int STAT_LEFT_SILENT = 2;
  localparam int STAT_RIGHT_SILENT = 3;

  // reset values and the volume mute code
  localparam logic [TIME_FIELD_W-1:0] TIME_RESET = 3'h0;
  localparam logic [LINK_FIELD_W-1:0] LINK_RESET = 2'h0;
  localparam logic [REG_DATA_W-1:0] VOLUME_RESET = 8'h30;
  localparam logic [REG_DATA_W-1:0] VOLUME_MUTE_CODE = 8'hFF;

  // zero-run durations in microseconds, defined at the reference rate
  localparam longint REF_RATE_HZ = 96000;
  localparam longint US_PER_S = 1000000;
  localparam longint RUN_TIME_US [8] = '{
    11500, 53000, 106500, 266500, 535000, 1065000, 2665000, 5330000
  };

  typedef enum logic [LINK_FIELD_W-1:0] {
    LINK_INDEPENDENT = 2'h0,
    LINK_FOLLOW_LEFT = 2'h1
  } link_mode_e;

  // sample count for a time code at the given sample rate
  function automatic logic [RUN_W-1:0] runLimit(
    input logic [TIME_FIELD_W-1:0] code,
    input longint rateHz
  );
    longint samples;
    samples = (RUN_TIME_US[code] * rateHz) / US_PER_S;
    if (samples < 1) begin
      samples = 1;
    end
    return samples[RUN_W-1:0];
  endfunction

endpackage

/* zero_run_if.sv */
interface zero_run_if;
  import auto_mute_pkg::*;
  logic sampleStrobe;
  logic isZero;
  logic [RUN_W-1:0] limit;
  logic runMuted;

  modport owner (
    output sampleStrobe,
    output isZero,
    output limit,
    input runMuted
  );

  modport counter (
    input sampleStrobe,
    input isZero,
    input limit,
    output runMuted
  );
endinterface

/* zero_run_counter.sv */
module zero_run_counter
  import auto_mute_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  zero_run_if.counter run
);

  logic [RUN_W-1:0] count_reg;
  logic [RUN_W-1:0] count_next;
  logic muted_reg;
  logic muted_next;

  always_comb begin
    count_next = count_reg;
    if (run.sampleStrobe) begin
      if (!run.isZero) begin
        count_next = '0;
      end else if (count_reg != {RUN_W{1'b1}}) begin
        // saturate so a very long silence stays muted
        count_next = count_reg + 1'b1;
      end
    end
    muted_next = (count_next >= run.limit);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      muted_reg <= 1'b0;
    end else if (clkEn) begin
      count_reg <= count_next;
      muted_reg <= muted_next;
    end
  end

  assign run.runMuted = muted_reg;

endmodule

/* auto_mute_volume_link.sv */
// Notes on behaviour
// R1 - left mutes only after an unbroken zero run of at least its time
// R2 - right mutes only after an unbroken zero run of at least its time
// R3 - left time field bits 6:4, reset 0, codes 11.5 ms to 5.33 s
// R4 - right time field bits 2:0, reset 0, same eight-step duration code
// R5 - durations hold at 96 kHz; fixed sample counts scale with rate
// R6 - link code 00 applies each volume to its own channel
// R7 - link code 01 applies the left volume to both channels
// R8 - volume codes step 0.5 dB from +24 dB; 30h is 0 dB, FFh mutes
// R9 - any nonzero sample restarts that channel's zero-run count
module auto_mute_volume_link
  import auto_mute_pkg::*;
#(
  parameter longint RUN_RATE_HZ = REF_RATE_HZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [auto_mute_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [auto_mute_pkg::WB_DATA_W-1:0] wb_dat_i,
  output logic [auto_mute_pkg::WB_DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sampleValid,
  input wire logic [auto_mute_pkg::SAMPLE_W-1:0] leftSample,
  input wire logic [auto_mute_pkg::SAMPLE_W-1:0] rightSample,
  output logic leftAutoMute,
  output logic rightAutoMute,
  output logic [auto_mute_pkg::REG_DATA_W-1:0] leftVolumeApplied,
  output logic [auto_mute_pkg::REG_DATA_W-1:0] rightVolumeApplied,
  output logic leftSilenced,
  output logic rightSilenced
);

  import auto_mute_pkg::*;

  // configuration registers
  logic [TIME_FIELD_W-1:0] left_zero_run_time_reg;
  logic [TIME_FIELD_W-1:0] left_zero_run_time_next;
  logic [TIME_FIELD_W-1:0] right_zero_run_time_reg;
  logic [TIME_FIELD_W-1:0] right_zero_run_time_next;
  logic [LINK_FIELD_W-1:0] volume_link_select_reg;
  logic [LINK_FIELD_W-1:0] volume_link_select_next;
  logic [REG_DATA_W-1:0] left_volume_code_reg;
  logic [REG_DATA_W-1:0] left_volume_code_next;
  logic [REG_DATA_W-1:0] right_volume_code_reg;
  logic [REG_DATA_W-1:0] right_volume_code_next;

  // bus answer
  logic ack_reg;
  logic ack_next;
  logic [WB_DATA_W-1:0] rdata_reg;
  logic [WB_DATA_W-1:0] rdata_next;

  // applied outputs
  logic [REG_DATA_W-1:0] leftApplied_reg;
  logic [REG_DATA_W-1:0] leftApplied_next;
  logic [REG_DATA_W-1:0] rightApplied_reg;
  logic [REG_DATA_W-1:0] rightApplied_next;
  logic leftSilenced_reg;
  logic leftSilenced_next;
  logic rightSilenced_reg;
  logic rightSilenced_next;

  logic busReq;
  logic busWrite;
  logic [IDX_W-1:0] regIdx;
  logic [CHANNELS-1:0] chanMuted;
  logic [SAMPLE_W-1:0] chanSample [CHANNELS];
  logic [TIME_FIELD_W-1:0] chanTime [CHANNELS];

  zero_run_if runPort [CHANNELS] ();

  // a new request is one not yet answered; ack drops the cycle after
  assign busReq = wb_cyc_i && wb_stb_i && !ack_reg;
  assign busWrite = busReq && wb_we_i && wb_sel_i[0];
  assign regIdx = wb_adr_i[WB_ADR_W-1:2];

  assign chanSample[CH_LEFT] = leftSample;
  assign chanSample[CH_RIGHT] = rightSample;
  assign chanTime[CH_LEFT] = left_zero_run_time_reg;
  assign chanTime[CH_RIGHT] = right_zero_run_time_reg;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      assign runPort[ch].sampleStrobe = sampleValid;
      assign runPort[ch].isZero = (chanSample[ch] == '0); // R9
      // count of samples, not of clocks, so time follows the rate
      assign runPort[ch].limit =
        runLimit(chanTime[ch], RUN_RATE_HZ); // R5
      assign chanMuted[ch] = runPort[ch].runMuted;

      zero_run_counter u_counter (
        .clk(clk),
        .rst(rst),
        .clkEn(clkEn),
        .run(runPort[ch])
      );
    end
  endgenerate

  assign leftAutoMute = chanMuted[CH_LEFT]; // R1
  assign rightAutoMute = chanMuted[CH_RIGHT]; // R2

  // register writes
  always_comb begin
    left_zero_run_time_next = left_zero_run_time_reg;
    right_zero_run_time_next = right_zero_run_time_reg;
    volume_link_select_next = volume_link_select_reg;
    left_volume_code_next = left_volume_code_reg;
    right_volume_code_next = right_volume_code_reg;
    if (busWrite) begin
      unique case (regIdx)
        IDX_AUTO_MUTE_TIME: begin
          left_zero_run_time_next =
            wb_dat_i[LEFT_TIME_LSB +: TIME_FIELD_W]; // R3
          right_zero_run_time_next =
            wb_dat_i[RIGHT_TIME_LSB +: TIME_FIELD_W]; // R4
        end
        IDX_VOLUME_LINK_CONTROL: begin
          volume_link_select_next = wb_dat_i[LINK_LSB +: LINK_FIELD_W];
        end
        IDX_LEFT_VOLUME: begin
          left_volume_code_next = wb_dat_i[REG_DATA_W-1:0];
        end
        IDX_RIGHT_VOLUME: begin
          right_volume_code_next = wb_dat_i[REG_DATA_W-1:0];
        end
        default: begin
          // unmapped or read-only: write is acknowledged and dropped
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_zero_run_time_reg <= TIME_RESET;
      right_zero_run_time_reg <= TIME_RESET;
      volume_link_select_reg <= LINK_RESET;
      left_volume_code_reg <= VOLUME_RESET;
      right_volume_code_reg <= VOLUME_RESET;
    end else if (clkEn) begin
      left_zero_run_time_reg <= left_zero_run_time_next;
      right_zero_run_time_reg <= right_zero_run_time_next;
      volume_link_select_reg <= volume_link_select_next;
      left_volume_code_reg <= left_volume_code_next;
      right_volume_code_reg <= right_volume_code_next;
    end
  end

  // bus answer: one wait state, read data registered with the ack
  always_comb begin
    ack_next = busReq;
    rdata_next = '0;
    if (busReq && !wb_we_i) begin
      unique case (regIdx)
        IDX_AUTO_MUTE_TIME: begin
          rdata_next[LEFT_TIME_LSB +: TIME_FIELD_W] = left_zero_run_time_reg;
          rdata_next[RIGHT_TIME_LSB +: TIME_FIELD_W] =
            right_zero_run_time_reg;
        end
        IDX_VOLUME_LINK_CONTROL: begin
          rdata_next[LINK_LSB +: LINK_FIELD_W] = volume_link_select_reg;
        end
        IDX_LEFT_VOLUME: begin
          rdata_next[REG_DATA_W-1:0] = left_volume_code_reg;
        end
        IDX_RIGHT_VOLUME: begin
          rdata_next[REG_DATA_W-1:0] = right_volume_code_reg;
        end
        IDX_MUTE_STATUS: begin
          rdata_next[STAT_LEFT_AUTO] = chanMuted[CH_LEFT];
          rdata_next[STAT_RIGHT_AUTO] = chanMuted[CH_RIGHT];
          rdata_next[STAT_LEFT_SILENT] = leftSilenced_reg;
          rdata_next[STAT_RIGHT_SILENT] = rightSilenced_reg;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end else if (clkEn) begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // volume linking and mute code decode
  always_comb begin
    leftApplied_next = left_volume_code_reg;
    rightApplied_next = right_volume_code_reg; // R6
    // reserved link codes behave as independent
    if (volume_link_select_reg == LINK_FOLLOW_LEFT) begin
      rightApplied_next = left_volume_code_reg; // R7
    end
    // the top code silences outright rather than attenuating
    leftSilenced_next =
      (leftApplied_next == VOLUME_MUTE_CODE) || chanMuted[CH_LEFT]; // R8
    rightSilenced_next =
      (rightApplied_next == VOLUME_MUTE_CODE) || chanMuted[CH_RIGHT]; // R8
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      leftApplied_reg <= VOLUME_RESET;
      rightApplied_reg <= VOLUME_RESET;
      leftSilenced_reg <= 1'b0;
      rightSilenced_reg <= 1'b0;
    end else if (clkEn) begin
      leftApplied_reg <= leftApplied_next;
      rightApplied_reg <= rightApplied_next;
      leftSilenced_reg <= leftSilenced_next;
      rightSilenced_reg <= rightSilenced_next;
    end
  end

  assign leftVolumeApplied = leftApplied_reg;
  assign rightVolumeApplied = rightApplied_reg;
  assign leftSilenced = leftSilenced_reg;
  assign rightSilenced = rightSilenced_reg;

endmodule

/* auto_mute_asserts.sv */
module auto_mute_asserts
  import auto_mute_pkg::*;
#(
  parameter longint RUN_RATE_HZ = REF_RATE_HZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [auto_mute_pkg::WB_DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sampleValid,
  input wire logic [auto_mute_pkg::SAMPLE_W-1:0] leftSample,
  input wire logic [auto_mute_pkg::SAMPLE_W-1:0] rightSample,
  input wire logic leftAutoMute,
  input wire logic rightAutoMute,
  input wire logic [auto_mute_pkg::REG_DATA_W-1:0] leftVolumeApplied,
  input wire logic [auto_mute_pkg::REG_DATA_W-1:0] rightVolumeApplied,
  input wire logic leftSilenced,
  input wire logic rightSilenced
);
  timeunit 1ns;
  timeprecision 1ps;
  // shortest code is the floor for every code, so no register copy needed
  localparam longint MIN_RUN = RUN_TIME_US[0] * RUN_RATE_HZ / US_PER_S;
  logic [19:0] leftRun_reg, leftRun_next, rightRun_reg, rightRun_next;
  wire logic take = clkEn && sampleValid;

  always_comb begin
    leftRun_next = leftRun_reg;
    rightRun_next = rightRun_reg;
    if (take) begin
      leftRun_next = (leftSample != '0) ? '0 :
        leftRun_reg + 20'(~&leftRun_reg);
      rightRun_next = (rightSample != '0) ? '0 :
        rightRun_reg + 20'(~&rightRun_reg);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      leftRun_reg <= '0;
      rightRun_reg <= '0;
    end else begin
      leftRun_reg <= leftRun_next;
      rightRun_reg <= rightRun_next;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_left_run_long: assert property (
    leftAutoMute |-> leftRun_reg >= MIN_RUN) else $error("left early mute");
  a_right_run_long: assert property (
    rightAutoMute |-> rightRun_reg >= MIN_RUN)
    else $error("right early mute");
  a_left_nonzero_clear: assert property (
    take && leftSample != '0 |=> !leftAutoMute) else $error("left kept mute");
  a_right_nonzero_clear: assert property (
    take && rightSample != '0 |=> !rightAutoMute)
    else $error("right kept mute");
  // silenced and applied code share one register stage, automute leads by one
  a_left_silence_follows: assert property (
    clkEn && leftAutoMute |=> leftSilenced) else $error("left not silenced");
  a_right_silence_follows: assert property (
    clkEn && rightAutoMute |=> rightSilenced)
    else $error("right not silenced");
  a_left_code_silence: assert property (
    leftVolumeApplied == VOLUME_MUTE_CODE |-> leftSilenced)
    else $error("left code not silenced");
  a_right_code_silence: assert property (
    rightVolumeApplied == VOLUME_MUTE_CODE |-> rightSilenced)
    else $error("right code not silenced");
  a_ack_follows_req: assert property (
    clkEn && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_ack_one_cycle: assert property (
    clkEn && wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_read_upper_zero: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == '0) else $error("upper data set");

  c_left_mute: cover property ($rose(leftAutoMute));
  c_right_mute: cover property ($rose(rightAutoMute));
  c_bus_ack: cover property (wb_ack_o);
endmodule

/* auto_mute_volume_link_test.sv */
module auto_mute_volume_link_test;
  timeunit 1ns;
  timeprecision 1ps;
  import auto_mute_pkg::*;
  localparam longint RATE = 1000;
  localparam longint US_T [8] = '{11500, 53000, 106500, 266500,
    535000, 1065000, 2665000, 5330000};
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, valid = 0;
  logic [9:0] adr = '0;
  logic [31:0] wdat = '0, rdat, lS = '0, rS = '0;
  logic ack, lMute, rMute, lSil, rSil;
  logic [7:0] lVol, rVol;
  int numErrors = 0, totalChecks = 0;

  auto_mute_volume_link #(.RUN_RATE_HZ(RATE)) dut (.clk(clk), .rst(rst),
    .clkEn(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sampleValid(valid), .leftSample(lS),
    .rightSample(rS), .leftAutoMute(lMute), .rightAutoMute(rMute),
    .leftVolumeApplied(lVol), .rightVolumeApplied(rVol),
    .leftSilenced(lSil), .rightSilenced(rSil));

  always #4 clk = ~clk;

  task results;
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task check(input logic [31:0] got, exp, input string msg);
    totalChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task bus(input logic w, input logic [9:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      numErrors++;
      $display("[ERR] %0t no ack", $time);
      results();
    end
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask

  task wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1, a, d, q);
  endtask

  task rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(0, a, 0, q);
    check(q, e, "read");
  endtask

  // nonzero samples restart the run, so callers use this to clear counts
  task feed(input longint n, input logic [31:0] l, r);
    repeat (n) begin
      @(posedge clk);
      valid <= 1;
      lS <= l;
      rS <= r;
    end
    @(posedge clk);
    valid <= 0;
    @(posedge clk);
  endtask

  task testReset;
    check(lVol, 8'h30, "vol reset");
    rd(10'h0EC, 0);
    rd(10'h0F0, 0);
    rd(10'h0F8, 8'h30);
    rd(10'h3FC, 0);
    wr(10'h0EC, 8'hFF);
    rd(10'h0EC, 8'h77);
    wr(10'h0F0, 8'hFF);
    rd(10'h0F0, 8'h03);
    wr(10'h0F0, 0);
  endtask

  task testCodes;
    longint lim;
    for (int c = 0; c < 8; c++) begin
      lim = US_T[c] * RATE / 1000000;
      wr(10'h0EC, {25'h0, c[2:0], 1'b0, c[2:0]});
      feed(1, 1, 1);
      feed(lim - 1, 0, 0);
      check({lMute, rMute}, 0, "muted early");
      feed(1, 0, 0);
      check({lMute, rMute}, 3, "not muted");
    end
  endtask

  task testRestart;
    wr(10'h0EC, 8'h01);
    feed(1, 1, 1);
    feed(10, 0, 0);
    feed(1, 1, 0);
    feed(10, 0, 0);
    check(lMute, 0, "run not restarted");
    feed(1, 0, 0);
    check({lMute, rMute}, 2, "left run");
    feed(31, 0, 0);
    check(rMute, 1, "right run");
  endtask

  task testLink;
    wr(10'h0F4, 8'h10);
    wr(10'h0F8, 8'h80);
    feed(0, 0, 0);
    check({lVol, rVol}, 16'h1080, "independent");
    wr(10'h0F0, 1);
    feed(0, 0, 0);
    check(rVol, 8'h10, "follow left");
    wr(10'h0F4, 8'hFF);
    feed(0, 0, 0);
    check({rVol, lSil}, 9'h1FF, "mute code");
    feed(1, 1, 1);
    check({lMute, rMute, lSil, rSil}, 4'h3, "code mute only");
    rd(10'h100, 8'h0C);
    wr(10'h0F0, 0);
    wr(10'h0F4, 8'h30);
    feed(0, 0, 0);
    check({lVol, rVol}, 16'h3080, "independent again");
    check({lSil, rSil}, 0, "still silenced");
    feed(11, 0, 5);
    rd(10'h100, 8'h05);
    check(rSil, 0, "right silenced");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    testReset();
    testCodes();
    testRestart();
    testLink();
    results();
  end

  initial begin
    repeat (40000) @(posedge clk);
    $display("[ERR] %0t watchdog expired", $time);
    numErrors++;
    results();
  end
endmodule

bind auto_mute_volume_link auto_mute_asserts #(.RUN_RATE_HZ(RUN_RATE_HZ))
  chk (.clk(clk), .rst(rst), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sampleValid(sampleValid), .leftSample(leftSample),
  .rightSample(rightSample), .leftAutoMute(leftAutoMute),
  .rightAutoMute(rightAutoMute), .leftVolumeApplied(leftVolumeApplied),
  .rightVolumeApplied(rightVolumeApplied),
  .leftSilenced(leftSilenced), .rightSilenced(rightSilenced));
